// [hdl/uetr_regs.sv]
// apb register bank holding endpoint fifo placement and host-mode target addressing
`timescale 1ns/1ps
`include "uetr_consts.svh"

module uetr_regs (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // configuration towards the packet engine
    output uetr_pkg::uetr_dir_cfg_t TX_CFG,
    output uetr_pkg::uetr_dir_cfg_t RX_CFG,
    output logic [15:0] TX_FIFO_BYTE,
    output logic [15:0] RX_FIFO_BYTE
);
    import uetr_pkg::*;

    // all assertions of this block run on the one clock and are off during reset, except AST_RESET_ZERO, which is never disabled
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------

    // map a byte address to a register selection
    function automatic uetr_sel_t decode(input logic [11:0] addr);
        uetr_sel_t sel;
        case (addr)
            `UETR_OFS_TX_FIFO_START: sel = UETR_SEL_TX_FIFO;
            `UETR_OFS_RX_FIFO_START: sel = UETR_SEL_RX_FIFO;
            `UETR_OFS_TX_TARGET_FUNC: sel = UETR_SEL_TX_FUNC;
            `UETR_OFS_TX_HUB_NUMBER: sel = UETR_SEL_TX_HUB;
            `UETR_OFS_TX_HUB_PORT: sel = UETR_SEL_TX_PORT;
            `UETR_OFS_RX_TARGET_FUNC: sel = UETR_SEL_RX_FUNC;
            `UETR_OFS_RX_HUB_NUMBER: sel = UETR_SEL_RX_HUB;
            `UETR_OFS_RX_HUB_PORT: sel = UETR_SEL_RX_PORT;
            default: sel = UETR_SEL_NONE;
        endcase
        return sel;
    endfunction

    // byte address of a buffer start held in 8-byte units
    function automatic logic [15:0] fifo_bytes(input logic [12:0] units);
        return {units, 3'h0};
    endfunction

    // ------------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------------

    uetr_state_t state_q;
    uetr_dir_cfg_t tx_q;
    uetr_dir_cfg_t rx_q;
    uetr_sel_t sel;
    logic access;
    logic complete;
    logic wr_en;
    logic [31:0] rd_word;

    // access phase, and the edge at which it completes
    assign sel = decode(PADDR);
    assign access = PSEL && PENABLE;
    assign complete = access && (state_q == UETR_ST_DONE);
    assign wr_en = complete && PWRITE && (sel != UETR_SEL_NONE);

    // read data assembly, reserved bits forced to zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (sel)
            UETR_SEL_TX_FIFO: rd_word[12:0] = tx_q.fifo_start;
            UETR_SEL_RX_FIFO: rd_word[12:0] = rx_q.fifo_start;
            UETR_SEL_TX_FUNC: rd_word[6:0] = tx_q.target_function_number;
            UETR_SEL_TX_HUB: rd_word[7:0] = {tx_q.multi_translator_flag, tx_q.hub_device_number};
            UETR_SEL_TX_PORT: rd_word[6:0] = tx_q.hub_port_index;
            UETR_SEL_RX_FUNC: rd_word[6:0] = rx_q.target_function_number;
            UETR_SEL_RX_HUB: rd_word[7:0] = {rx_q.multi_translator_flag, rx_q.hub_device_number};
            UETR_SEL_RX_PORT: rd_word[6:0] = rx_q.hub_port_index;
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------------
    // apb handshake: one wait cycle, answer from flops
    // ------------------------------------------------------------------------

    // wait state sequencing
    always_ff @(posedge CLK)
    begin
        if (RESET)
            state_q <= UETR_ST_IDLE;
        else
        begin
            case (state_q)
                UETR_ST_IDLE: if (access) state_q <= UETR_ST_DONE;
                UETR_ST_DONE: state_q <= UETR_ST_IDLE;
                default: state_q <= UETR_ST_IDLE;
            endcase
        end
    end

    // ready, read data and error, all registered
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else
        begin
            PREADY <= access && (state_q == UETR_ST_IDLE);
            PRDATA <= (access && !PWRITE && state_q == UETR_ST_IDLE) ? rd_word : 32'h0000_0000;
            PSLVERR <= access && (state_q == UETR_ST_IDLE) && (sel == UETR_SEL_NONE);
        end
    end

    // ------------------------------------------------------------------------
    // configuration storage
    // ------------------------------------------------------------------------

    // transmit direction fields, written at the completing edge
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            tx_q.fifo_start <= `UETR_RESET_FIFO_START;
            tx_q.target_function_number <= `UETR_RESET_NUM7;
            tx_q.multi_translator_flag <= `UETR_RESET_FLAG;
            tx_q.hub_device_number <= `UETR_RESET_NUM7;
            tx_q.hub_port_index <= `UETR_RESET_NUM7;
        end
        else if (wr_en)
        begin
            case (sel)
                UETR_SEL_TX_FIFO: tx_q.fifo_start <= PWDATA[12:0];
                UETR_SEL_TX_FUNC: tx_q.target_function_number <= PWDATA[6:0];
                UETR_SEL_TX_HUB:
                begin
                    tx_q.multi_translator_flag <= PWDATA[`UETR_MULTI_TT_BIT];
                    tx_q.hub_device_number <= PWDATA[6:0];
                end
                UETR_SEL_TX_PORT: tx_q.hub_port_index <= PWDATA[6:0];
                default: tx_q <= tx_q;
            endcase
        end
    end

    // receive direction fields, written at the completing edge
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            rx_q.fifo_start <= `UETR_RESET_FIFO_START;
            rx_q.target_function_number <= `UETR_RESET_NUM7;
            rx_q.multi_translator_flag <= `UETR_RESET_FLAG;
            rx_q.hub_device_number <= `UETR_RESET_NUM7;
            rx_q.hub_port_index <= `UETR_RESET_NUM7;
        end
        else if (wr_en)
        begin
            case (sel)
                UETR_SEL_RX_FIFO: rx_q.fifo_start <= PWDATA[12:0];
                UETR_SEL_RX_FUNC: rx_q.target_function_number <= PWDATA[6:0];
                UETR_SEL_RX_HUB:
                begin
                    rx_q.multi_translator_flag <= PWDATA[`UETR_MULTI_TT_BIT];
                    rx_q.hub_device_number <= PWDATA[6:0];
                end
                UETR_SEL_RX_PORT: rx_q.hub_port_index <= PWDATA[6:0];
                default: rx_q <= rx_q;
            endcase
        end
    end

    // outputs are the stored fields; byte addresses are plain shifted wiring
    assign TX_CFG = tx_q;
    assign RX_CFG = rx_q;
    assign TX_FIFO_BYTE = fifo_bytes(tx_q.fifo_start);
    assign RX_FIFO_BYTE = fifo_bytes(rx_q.fifo_start);

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------

    logic wr_tx_fifo;
    logic wr_rx_fifo;
    assign wr_tx_fifo = wr_en && sel == UETR_SEL_TX_FIFO;
    assign wr_rx_fifo = wr_en && sel == UETR_SEL_RX_FIFO;

    AST_TX_FIFO_BYTES: assert property (
        wr_tx_fifo |=> TX_FIFO_BYTE == {$past(PWDATA[12:0]), 3'h0})
        else $error("tx fifo byte address not eight times the written start");
    AST_RX_FIFO_BYTES: assert property (
        wr_rx_fifo |=> RX_FIFO_BYTE == {$past(PWDATA[12:0]), 3'h0} && RX_FIFO_BYTE[2:0] == 3'h0)
        else $error("rx fifo byte address not eight times the written start");
    AST_FUNC_WRITE: assert property (
        (wr_en && sel == UETR_SEL_TX_FUNC) |=>
        TX_CFG.target_function_number == $past(PWDATA[6:0]) && $stable(RX_CFG))
        else $error("tx target function not stored or rx disturbed");
    AST_HUB_FLAG: assert property (
        (wr_en && sel == UETR_SEL_RX_HUB) |=>
        RX_CFG.multi_translator_flag == $past(PWDATA[7]) &&
        RX_CFG.hub_device_number == $past(PWDATA[6:0]))
        else $error("rx hub number or translator flag not stored");
    AST_PORT_WRITE: assert property (
        (wr_en && sel == UETR_SEL_TX_PORT) |=> TX_CFG.hub_port_index == $past(PWDATA[6:0]))
        else $error("tx hub port index not stored");
    AST_RESV_READ: assert property (
        (access && !PWRITE && state_q == UETR_ST_IDLE && sel == UETR_SEL_TX_PORT) |=>
        PREADY && PRDATA[31:7] == 25'h0 && PRDATA[6:0] == TX_CFG.hub_port_index)
        else $error("reserved bits of a port read not zero");
    AST_RESET_ZERO: assert property (disable iff (1'b0)
        RESET |=> TX_CFG == '0 && RX_CFG == '0 && !PREADY)
        else $error("fields not zero after reset");
    AST_READY_ONE_WAIT: assert property (
        (access && !PREADY) |=> PREADY ##1 !PREADY)
        else $error("apb answer not after exactly one wait cycle");

    CV_TX_FIFO_WRITE: cover property (wr_tx_fifo ##1 TX_FIFO_BYTE != 16'h0000);
    CV_HUB_FLAG_SET: cover property (wr_en && sel == UETR_SEL_TX_HUB && PWDATA[7]);
    CV_UNMAPPED: cover property (complete && PSLVERR);
    CV_READ_BACK: cover property (complete && !PWRITE && PRDATA != 32'h0);

endmodule

// [hdl/uetr_consts.svh]
// offsets, field positions and reset values for the endpoint target registers
`ifndef UETR_CONSTS_SVH
`define UETR_CONSTS_SVH

// ----------------------------------------------------------------------------
// register byte offsets on the apb bus
// ----------------------------------------------------------------------------
`define UETR_OFS_TX_FIFO_START 12'h000
`define UETR_OFS_RX_FIFO_START 12'h004
`define UETR_OFS_TX_TARGET_FUNC 12'h008
`define UETR_OFS_TX_HUB_NUMBER 12'h00c
`define UETR_OFS_TX_HUB_PORT 12'h010
`define UETR_OFS_RX_TARGET_FUNC 12'h014
`define UETR_OFS_RX_HUB_NUMBER 12'h018
`define UETR_OFS_RX_HUB_PORT 12'h01c

// ----------------------------------------------------------------------------
// field layout
// ----------------------------------------------------------------------------
`define UETR_FIFO_START_W 13
`define UETR_FIFO_BYTE_W 16
`define UETR_FIFO_UNIT_SHIFT 3
`define UETR_NUM7_W 7
`define UETR_MULTI_TT_BIT 7
`define UETR_APB_ADDR_W 12

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define UETR_RESET_FIFO_START 13'h0000
`define UETR_RESET_NUM7 7'h00
`define UETR_RESET_FLAG 1'b0

`endif

// [hdl/uetr_pkg.sv]
// types shared by the endpoint target register bank
package uetr_pkg;

    // per-direction endpoint target configuration seen by the packet engine
    typedef struct packed {
        logic [12:0] fifo_start;        // buffer start in 8-byte units
        logic [6:0] target_function_number;
        logic multi_translator_flag;
        logic [6:0] hub_device_number;
        logic [6:0] hub_port_index;
    } uetr_dir_cfg_t;

    // decoded register selection
    typedef enum logic [3:0] {
        UETR_SEL_TX_FIFO = 4'h0,
        UETR_SEL_RX_FIFO = 4'h1,
        UETR_SEL_TX_FUNC = 4'h2,
        UETR_SEL_TX_HUB = 4'h3,
        UETR_SEL_TX_PORT = 4'h4,
        UETR_SEL_RX_FUNC = 4'h5,
        UETR_SEL_RX_HUB = 4'h6,
        UETR_SEL_RX_PORT = 4'h7,
        UETR_SEL_NONE = 4'h8
    } uetr_sel_t;

    // apb handshake state of the slave
    typedef enum logic [0:0] {
        UETR_ST_IDLE = 1'b0,
        UETR_ST_DONE = 1'b1
    } uetr_state_t;

endpackage

// [dv/uetr_apb_host.sv]
// apb host model standing in for processor software
`timescale 1ns/1ps

module uetr_apb_host (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request from the bench
    input wire logic go,
    input wire logic wr,
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    output logic done,
    output logic [31:0] rdata,
    output logic err,
    // apb master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // setup, then access held until pready, result taken at that edge
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
        else if (psel && penable && pready)
        begin
            psel <= 1'b0;
            penable <= 1'b0;
            rdata <= prdata;
            err <= pslverr;
        end
        else if (psel)
            penable <= 1'b1;
        else if (go)
        begin
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= addr;
            pwdata <= wdata;
        end
    end

    // completion pulse, one cycle after the edge that saw pready
    always_ff @(posedge clk)
    begin
        done <= !rst && psel && penable && pready;
    end
endmodule

// [dv/usb_endpoint_target_regs_tb.sv]
// self-checking bench for the endpoint target register bank
`timescale 1ns/1ps
`include "uetr_consts.svh"

module usb_endpoint_target_regs_tb;
    import uetr_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic go = 1'b0;
    logic wr = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic done, err, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] rdata, pwdata, prdata;
    logic [15:0] tx_byte, rx_byte;
    uetr_dir_cfg_t tx_cfg, rx_cfg;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [11:0] ofs [8] = '{`UETR_OFS_TX_FIFO_START, `UETR_OFS_RX_FIFO_START,
        `UETR_OFS_TX_TARGET_FUNC, `UETR_OFS_TX_HUB_NUMBER, `UETR_OFS_TX_HUB_PORT,
        `UETR_OFS_RX_TARGET_FUNC, `UETR_OFS_RX_HUB_NUMBER, `UETR_OFS_RX_HUB_PORT};
    logic [31:0] msk [8] = '{32'h1fff, 32'h1fff, 32'h7f, 32'hff, 32'h7f, 32'h7f, 32'hff, 32'h7f};

    // clock and timeout
    initial forever #2 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            mismatches++;
            final_report();
        end
    end

    uetr_apb_host i_host (.clk(clk), .rst(rst), .go(go), .wr(wr), .addr(addr),
        .wdata(wdata), .done(done), .rdata(rdata), .err(err), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    uetr_regs i_dut (.CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .TX_CFG(tx_cfg), .RX_CFG(rx_cfg),
        .TX_FIFO_BYTE(tx_byte), .RX_FIFO_BYTE(rx_byte));

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer through the host model; the wait ends on done, with no limit but the bench timeout
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        go <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        go <= 1'b0;
        while (done !== 1'b1)
        begin
            @(posedge clk);
            n++;
        end
        chk("handshake cycles", 64'(n), 64'h4);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic test_reset();
        for (int i = 0; i < 8; i++)
        begin
            xfer(1'b0, ofs[i], 32'h0);
            chk("reset value", 64'(rdata), 64'h0);
        end
        chk("tx cfg reset", 64'(tx_cfg), 64'h0);
        chk("rx cfg reset", 64'(rx_cfg), 64'h0);
        $display("test_reset done");
    endtask

    // all-ones then a mixed pattern; flag set then cleared
    task automatic test_fields();
        logic [31:0] pat [2] = '{32'hffffffff, 32'h12345678};
        logic [34:0] e;
        foreach (pat[k])
        begin
            for (int i = 0; i < 8; i++)
                xfer(1'b1, ofs[i], pat[k]);
            for (int i = 0; i < 8; i++)
            begin
                xfer(1'b0, ofs[i], 32'h0);
                chk("readback", 64'(rdata), 64'(pat[k] & msk[i]));
                chk("no error", 64'(err), 64'h0);
            end
            e = {pat[k][12:0], pat[k][6:0], pat[k][7], pat[k][6:0], pat[k][6:0]};
            chk("tx cfg", 64'(tx_cfg), 64'(e));
            chk("rx cfg", 64'(rx_cfg), 64'(e));
            chk("tx byte", 64'(tx_byte), 64'({pat[k][12:0], 3'b000}));
            chk("rx byte", 64'(rx_byte), 64'({pat[k][12:0], 3'b000}));
        end
        $display("test_fields done");
    endtask

    // hub with one shared translator: software clears the flag
    task automatic test_single_tt();
        xfer(1'b1, `UETR_OFS_TX_HUB_NUMBER, 32'hff);
        xfer(1'b1, `UETR_OFS_TX_HUB_NUMBER, 32'h05);
        chk("flag cleared", 64'(tx_cfg.multi_translator_flag), 64'h0);
        chk("hub number", 64'(tx_cfg.hub_device_number), 64'h5);
        $display("test_single_tt done");
    endtask

    // unmapped and unaligned addresses answer with an error and change nothing
    task automatic test_unmapped();
        xfer(1'b1, 12'h020, 32'hffffffff);
        chk("unmapped write err", 64'(err), 64'h1);
        xfer(1'b1, 12'h002, 32'h0);
        chk("unaligned write err", 64'(err), 64'h1);
        xfer(1'b0, 12'h002, 32'h0);
        chk("unaligned read data", 64'(rdata), 64'h0);
        xfer(1'b0, `UETR_OFS_TX_FIFO_START, 32'h0);
        chk("fifo start kept", 64'(rdata), 64'h1678);
        $display("test_unmapped done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_fields();
        test_single_tt();
        test_unmapped();
        final_report();
    end
endmodule
